// ==== cpsr_regs.sv ====
`timescale 1ns/1ps
module cpsr_regs #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata_r,
  input wire logic link_channel_error,
  input wire logic receiver_irq_pin,
  input wire logic receiver_lock_seen,
  input wire logic downstream_hotplug_event,
  input wire logic receiver_detect,
  input wire logic key_list_loaded,
  input wire logic key_vector_loaded,
  input wire logic is_repeater,
  input wire logic auth_pass,
  input wire logic auth_lost,
  input wire logic indirect_done,
  output logic auth_hold_r,
  output logic key_list_accepted_r,
  output logic key_vector_accepted_r,
  output logic auth_restart_r,
  output logic irq_r
);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic wr_handshake;
  logic wr_clear;
  logic wr_int_ctrl;
  logic wr_config;
  logic rd_status;
  logic list_ok_wr;
  logic key_ok_wr;
  logic restart_wr;

  assign wr_handshake = wr && (addr == cpsr_pkg::OFS_HANDSHAKE);
  assign wr_clear = wr && (addr == cpsr_pkg::OFS_IRQ_CLEAR);
  assign wr_int_ctrl = wr && (addr == cpsr_pkg::OFS_INT_CTRL);
  assign wr_config = wr && (addr == cpsr_pkg::OFS_CONFIG);
  assign rd_status = rd && (addr == cpsr_pkg::OFS_STATUS);
  assign list_ok_wr = wr_handshake && wdata[cpsr_pkg::HS_LIST_OK];
  assign key_ok_wr = wr_handshake && wdata[cpsr_pkg::HS_KEY_OK];
  assign restart_wr = wr_handshake && wdata[cpsr_pkg::HS_RESTART];

  // ************************************************************
  // software registers
  // ************************************************************
  logic [7:0] int_ctrl_r;
  logic wait_lock_sel_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_ctrl_r <= cpsr_pkg::RST_BYTE;
    end else if (wr_int_ctrl) begin
      int_ctrl_r <= wdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_lock_sel_r <= cpsr_pkg::RST_BIT;
    end else if (wr_config) begin
      wait_lock_sel_r <= wdata[cpsr_pkg::CF_WAIT_LOCK];
    end
  end

  // ************************************************************
  // status register
  // ************************************************************
  logic link_err_r;
  logic rx_irq_r;
  logic lock_r;
  logic hotplug_r;
  logic detect_r;
  logic list_rdy_r;
  logic key_rdy_r;
  logic auth_r;
  logic [7:0] status;

  // live levels are flopped so a read sees a stable value
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_irq_r <= cpsr_pkg::RST_BIT;
      lock_r <= cpsr_pkg::RST_BIT;
      detect_r <= cpsr_pkg::RST_BIT;
    end else begin
      rx_irq_r <= receiver_irq_pin;
      lock_r <= receiver_lock_seen;
      detect_r <= receiver_detect;
    end
  end

  // clear on read; an event in the read cycle survives
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_err_r <= cpsr_pkg::RST_BIT;
    end else if (link_channel_error) begin
      link_err_r <= 1'b1;
    end else if (rd_status) begin
      link_err_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hotplug_r <= cpsr_pkg::RST_BIT;
    end else if (downstream_hotplug_event) begin
      hotplug_r <= 1'b1;
    end else if (rd_status) begin
      hotplug_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      list_rdy_r <= cpsr_pkg::RST_BIT;
    end else if (key_list_loaded) begin
      list_rdy_r <= 1'b1;
    end else if (list_ok_wr || restart_wr) begin
      list_rdy_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      key_rdy_r <= cpsr_pkg::RST_BIT;
    end else if (key_vector_loaded) begin
      key_rdy_r <= 1'b1;
    end else if (key_ok_wr || restart_wr) begin
      key_rdy_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      auth_r <= cpsr_pkg::RST_BIT;
    end else if (auth_pass) begin
      auth_r <= 1'b1;
    end else if (auth_lost || restart_wr) begin
      auth_r <= 1'b0;
    end
  end

  always_comb begin
    status = cpsr_pkg::RST_BYTE;
    status[cpsr_pkg::ST_LINK_ERR] = link_err_r;
    status[cpsr_pkg::ST_RX_IRQ] = rx_irq_r;
    status[cpsr_pkg::ST_LOCK] = lock_r;
    status[cpsr_pkg::ST_HOTPLUG] = hotplug_r;
    status[cpsr_pkg::ST_DETECT] = detect_r;
    status[cpsr_pkg::ST_LIST_RDY] = list_rdy_r;
    status[cpsr_pkg::ST_KEY_RDY] = key_rdy_r;
    status[cpsr_pkg::ST_AUTH] = auth_r;
  end

  // ************************************************************
  // authentication hold
  // ************************************************************
  cpsr_pkg::cpsr_hold_t hold_r;
  cpsr_pkg::cpsr_hold_t hold_nxt;

  always_comb begin
    hold_nxt = hold_r;
    case (hold_r)
      cpsr_pkg::CPSR_RUN: begin
        if (key_list_loaded) begin
          hold_nxt = cpsr_pkg::CPSR_WAIT_LIST;
        end else if (key_vector_loaded && !is_repeater) begin
          hold_nxt = cpsr_pkg::CPSR_WAIT_KEY;
        end
      end
      cpsr_pkg::CPSR_WAIT_KEY: begin
        if (key_ok_wr) begin
          hold_nxt = cpsr_pkg::CPSR_RUN;
        end
      end
      cpsr_pkg::CPSR_WAIT_LIST: begin
        if (list_ok_wr) begin
          hold_nxt = cpsr_pkg::CPSR_RUN;
        end
      end
      default: begin
        hold_nxt = cpsr_pkg::CPSR_RUN;
      end
    endcase
    if (restart_wr) begin
      hold_nxt = cpsr_pkg::CPSR_RUN;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hold_r <= cpsr_pkg::CPSR_RUN;
      auth_hold_r <= cpsr_pkg::RST_BIT;
    end else begin
      hold_r <= hold_nxt;
      auth_hold_r <= (hold_nxt != cpsr_pkg::CPSR_RUN);
    end
  end

  // handshake pulses toward the authentication engine
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      key_list_accepted_r <= cpsr_pkg::RST_BIT;
      key_vector_accepted_r <= cpsr_pkg::RST_BIT;
      auth_restart_r <= cpsr_pkg::RST_BIT;
    end else begin
      key_list_accepted_r <= list_ok_wr;
      key_vector_accepted_r <= key_ok_wr;
      auth_restart_r <= restart_wr;
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  logic found_lvl;
  logic found_prev_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_set;

  // with the select set, detection only counts once lock is seen
  assign found_lvl = detect_r && (!wait_lock_sel_r || lock_r);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      found_prev_r <= cpsr_pkg::RST_BIT;
    end else begin
      found_prev_r <= found_lvl;
    end
  end

  always_comb begin
    irq_set = cpsr_pkg::RST_BYTE;
    irq_set[cpsr_pkg::IC_INDIRECT] = indirect_done;
    irq_set[cpsr_pkg::IC_RX_FOUND] = found_lvl && !found_prev_r;
  end

  // write one to clear; a new event in that cycle wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= cpsr_pkg::RST_BYTE;
    end else if (wr_clear) begin
      irq_stat_r <= irq_set | (irq_stat_r & ~wdata[7:0]);
    end else begin
      irq_stat_r <= irq_set | irq_stat_r;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_r <= cpsr_pkg::RST_BIT;
    end else begin
      irq_r <= int_ctrl_r[cpsr_pkg::IC_GLOBAL] &&
               (|(irq_stat_r & int_ctrl_r & cpsr_pkg::IRQ_SRC_MASK));
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else if (!rd) begin
      rdata_r <= '0;
    end else if (addr == cpsr_pkg::OFS_STATUS) begin
      rdata_r <= DATA_W'(status);
    end else if (addr == cpsr_pkg::OFS_INT_CTRL) begin
      rdata_r <= DATA_W'(int_ctrl_r);
    end else if (addr == cpsr_pkg::OFS_IRQ_STATUS) begin
      rdata_r <= DATA_W'(irq_stat_r);
    end else if (addr == cpsr_pkg::OFS_CONFIG) begin
      rdata_r <= DATA_W'({7'h00, wait_lock_sel_r});
    end else begin
      rdata_r <= '0;
    end
  end

endmodule : cpsr_regs

// ==== cpsr_pkg.sv ====
// What this block does
// - link error sets bit 7, read clears
// - bit 6 mirrors receiver interrupt pin, low active
// - bit 5 follows receiver lock
// - hot-plug event sets bit 4, read clears
// - bit 3 shows receiver detected
// - list loaded sets bit 2, authentication holds
// - list-accepted write clears bit 2
// - key vector loaded sets bit 1
// - non-repeater holds after key-ready until key accepted
// - key-accepted write clears bit 1
// - authentication pass sets bit 0
// - loss or restart clears bit 0
// - control bit 7 enables indirect-done interrupt
// - control bit 6 enables receiver-found interrupt
// - select bit delays receiver-found until lock
// - control bit 0 gates all interrupts globally
package cpsr_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_STATUS = 8'hc4;
  localparam logic [7:0] OFS_INT_CTRL = 8'hc6;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hd0;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'hd1;
  localparam logic [7:0] OFS_HANDSHAKE = 8'hd2;
  localparam logic [7:0] OFS_CONFIG = 8'hd3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_BIT = 1'b0;

  // ************************************************************
  // protection_status fields
  // ************************************************************
  localparam int ST_LINK_ERR = 7;
  localparam int ST_RX_IRQ = 6;
  localparam int ST_LOCK = 5;
  localparam int ST_HOTPLUG = 4;
  localparam int ST_DETECT = 3;
  localparam int ST_LIST_RDY = 2;
  localparam int ST_KEY_RDY = 1;
  localparam int ST_AUTH = 0;

  // ************************************************************
  // interrupt_control, irq status and clear fields
  // ************************************************************
  localparam int IC_INDIRECT = 7;
  localparam int IC_RX_FOUND = 6;
  localparam int IC_GLOBAL = 0;
  localparam logic [7:0] IRQ_SRC_MASK = 8'hc0;

  // ************************************************************
  // handshake and config fields
  // ************************************************************
  localparam int HS_LIST_OK = 5;
  localparam int HS_KEY_OK = 4;
  localparam int HS_RESTART = 0;
  localparam int CF_WAIT_LOCK = 0;

  // ************************************************************
  // authentication hold states
  // ************************************************************
  typedef enum logic [2:0] {
    CPSR_RUN = 3'b001,
    CPSR_WAIT_KEY = 3'b010,
    CPSR_WAIT_LIST = 3'b100
  } cpsr_hold_t;

endpackage : cpsr_pkg

// ==== cpsr_monitor.sv ====
`timescale 1ns/1ps
// ************************************************************
// port checker for the status and interrupt-control slice
// ************************************************************
module cpsr_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata_r,
  input wire logic key_list_loaded,
  input wire logic key_vector_loaded,
  input wire logic is_repeater,
  input wire logic indirect_done,
  input wire logic auth_hold_r,
  input wire logic key_list_accepted_r,
  input wire logic key_vector_accepted_r,
  input wire logic auth_restart_r,
  input wire logic irq_r
);
  logic [7:0] ctrl_q;
  logic hs_wr;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  assign hs_wr = wr && addr == 8'hd2;
  // shadow of the enable register as software wrote it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= 8'h00;
    end else if (wr && addr == 8'hc6) begin
      ctrl_q <= wdata;
    end
  end
  sequence s_ind;
    indirect_done ##1 (ctrl_q[7] && ctrl_q[0]);
  endsequence
  a_ind_irq: assert property (s_ind |=> irq_r)
    else $error("indirect done did not raise irq");
  a_global_gate: assert property (!$past(ctrl_q[0]) |-> !irq_r)
    else $error("irq high with global enable off");
  a_src_mask: assert property ($past(ctrl_q[7:6]) == 2'b00 |-> !irq_r)
    else $error("irq high with both sources masked");
  a_list_hold: assert property (key_list_loaded && !auth_hold_r |=> auth_hold_r)
    else $error("list load did not hold authentication");
  a_key_hold: assert property (key_vector_loaded && !is_repeater && !auth_hold_r |=> auth_hold_r)
    else $error("key load did not hold authentication");
  a_list_ok: assert property (hs_wr && wdata[5] |=> key_list_accepted_r)
    else $error("list accept pulse missing");
  a_key_ok: assert property (hs_wr && wdata[4] |=> key_vector_accepted_r ##1 !key_vector_accepted_r)
    else $error("key accept pulse wrong");
  a_restart_go: assert property (hs_wr && wdata[0] |=> auth_restart_r)
    else $error("restart pulse missing");
  a_rdata_idle: assert property (!rd |=> rdata_r == 8'h00)
    else $error("read data outside read answer");
endmodule : cpsr_monitor
bind cpsr_regs cpsr_monitor cpsr_monitor_i (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata_r(rdata_r), .key_list_loaded(key_list_loaded),
  .key_vector_loaded(key_vector_loaded), .is_repeater(is_repeater), .indirect_done(indirect_done),
  .auth_hold_r(auth_hold_r), .key_list_accepted_r(key_list_accepted_r),
  .key_vector_accepted_r(key_vector_accepted_r), .auth_restart_r(auth_restart_r), .irq_r(irq_r));

// ==== cpsr_far_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// downstream receiver and authentication engine stand-in
// ************************************************************
module cpsr_far_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [6:0] ev_req,
  input wire logic [3:0] lv_req,
  output logic [6:0] ev_out,
  output logic [3:0] lv_out
);
  // events leave as one-cycle pulses, levels a cycle late; idle pin high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ev_out <= 7'h00;
      lv_out <= 4'h1;
    end else begin
      ev_out <= ev_req;
      lv_out <= lv_req;
    end
  end
endmodule : cpsr_far_model

// ==== tb_content_protection_status_regs.sv ====
`timescale 1ns/1ps
// ************************************************************
// random event walk against a behavioural model
// ************************************************************
module tb_content_protection_status_regs;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [3:0] lv = 4'h1;
  logic [6:0] evo;
  logic [3:0] lvo;
  logic [7:0] rdata_r, got, d, m_ctrl, m_ist;
  logic hold, irq;
  logic [31:0] seed = 32'h38db_db74;
  logic [31:0] r;
  bit m_err, m_hp, m_list, m_key, m_auth, sel, cnd;
  int m_hold, miscompares, total_checks;

  always #12.5 clock = ~clock;

  cpsr_far_model cpsr_far_model_i (.clock(clock), .rstn(rstn), .ev_req(ev), .lv_req(lv),
    .ev_out(evo), .lv_out(lvo));
  cpsr_regs cpsr_regs_i (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_r(rdata_r), .link_channel_error(evo[0]), .receiver_irq_pin(lvo[0]),
    .receiver_lock_seen(lvo[1]), .downstream_hotplug_event(evo[1]), .receiver_detect(lvo[2]),
    .key_list_loaded(evo[2]), .key_vector_loaded(evo[3]), .is_repeater(lvo[3]),
    .auth_pass(evo[4]), .auth_lost(evo[5]), .indirect_done(evo[6]), .auth_hold_r(hold),
    .key_list_accepted_r(), .key_vector_accepted_r(), .auth_restart_r(), .irq_r(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata_r;
  endtask : rreg

  // receiver-found fires on a rise of detect qualified by lock when selected
  task automatic upd_cnd;
    if (lv[2] && (!sel || lv[1]) && !cnd) begin
      m_ist[6] = 1'b1;
    end
    cnd = lv[2] && (!sel || lv[1]);
  endtask : upd_cnd

  task give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #125000;
    miscompares++;
    give_verdict;
  end

  initial begin
    m_ctrl = 8'h00;
    m_ist = 8'h00;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    rreg(8'hc6);
    chk(got, 8'h00);
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      r = seed;
      if (r[5:3] == 3'h0) begin
        wreg(8'hd3, {7'h00, r[23]});
        sel = r[23];
        upd_cnd();
      end
      @(posedge clock);
      lv <= r[19:16];
      repeat (4) @(posedge clock);
      upd_cnd();
      if (r[2:0] != 3'h7) begin
        ev <= 7'h01 << r[2:0];
        @(posedge clock);
        ev <= 7'h00;
      end
      case (r[2:0])
        3'h0: m_err = 1'b1;
        3'h1: m_hp = 1'b1;
        3'h2: begin
          m_list = 1'b1;
          if (m_hold == 0) m_hold = 2;
        end
        3'h3: begin
          m_key = 1'b1;
          if (m_hold == 0 && !lv[3]) m_hold = 1;
        end
        3'h4: m_auth = 1'b1;
        3'h5: m_auth = 1'b0;
        3'h6: m_ist[7] = 1'b1;
        default: begin
          d = r[15:8] & 8'h31;
          if (!m_key) d[4] = 1'b0;
          wreg(8'hd2, d);
          if (d[5]) begin
            m_list = 1'b0;
            if (m_hold == 2) m_hold = 0;
          end
          if (d[4]) begin
            m_key = 1'b0;
            if (m_hold == 1) m_hold = 0;
          end
          if (d[0]) begin
            {m_list, m_key, m_auth} = 3'b000;
            m_hold = 0;
          end
        end
      endcase
      if (r[21]) begin
        m_ctrl = r[31:24] | (r[22] ? 8'h81 : 8'h00);
        wreg(8'hc6, m_ctrl);
      end
      if (r[20]) begin
        wreg(8'hd1, r[31:24]);
        m_ist = m_ist & ~r[31:24];
      end
      repeat (4) @(posedge clock);
      rreg(8'hc4);
      chk(got, {m_err, lv[0], lv[1], m_hp, lv[2], m_list, m_key, m_auth});
      {m_err, m_hp} = 2'b00;
      rreg(8'hd0);
      chk(got, m_ist);
      rreg(8'hc6);
      chk(got, m_ctrl);
      chk({7'h00, irq}, {7'h00, m_ctrl[0] && |(m_ist & m_ctrl & 8'hc0)});
      chk({7'h00, hold}, {7'h00, m_hold != 0});
    end
    rreg(8'he0);
    chk(got, 8'h00);
    rreg(8'hd2);
    chk(got, 8'h00);
    give_verdict;
  end
endmodule : tb_content_protection_status_regs
